// ### src/tlv_pkg.sv
// Package for the two-level vectored interrupt controller.
// Assumes one core clock; the special-function registers sit on the core's
// internal register port at their fixed 8-bit addresses.
package tlv_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register addresses and reset value
  localparam logic [7:0] ADDR_ENABLE_PRIMARY   = 8'ha8;
  localparam logic [7:0] ADDR_ENABLE_SECONDARY = 8'ha9;
  localparam logic [7:0] ADDR_PRIORITY_SELECT  = 8'hb8;
  localparam logic [7:0] REG_RESET             = 8'h00;
  localparam logic [7:0] SECONDARY_USED_MASK   = 8'h03;

  // Primary enable bit positions
  localparam int GLOBAL_IRQ_GATE   = 7;
  localparam int CONVERTER_IRQ_ON  = 6;
  localparam int TIMER2_IRQ_ON     = 5;
  localparam int UART_IRQ_ON       = 4;
  localparam int TIMER1_IRQ_ON     = 3;
  localparam int EXT1_IRQ_ON       = 2;
  localparam int TIMER0_IRQ_ON     = 1;
  localparam int EXT0_IRQ_ON       = 0;
  // Secondary enable bit positions
  localparam int SUPPLY_MONITOR_IRQ_ON = 1;
  localparam int TWOWIRE_SPI_IRQ_ON    = 0;
  // Priority select bit positions
  localparam int TWOWIRE_SPI_LEVEL = 7;
  localparam int CONVERTER_LEVEL   = 6;
  localparam int TIMER2_LEVEL      = 5;
  localparam int UART_LEVEL        = 4;
  localparam int TIMER1_LEVEL      = 3;
  localparam int EXT1_LEVEL        = 2;
  localparam int TIMER0_LEVEL      = 1;
  localparam int EXT0_LEVEL        = 0;

  ////////////////////////////////////////////////////////////////////////
  // Sources in polling order, index 0 is polled first
  localparam int NUM_SOURCES = 9;
  localparam int SRC_SUPPLY  = 0;
  localparam int SRC_EXT0    = 1;
  localparam int SRC_CONV    = 2;
  localparam int SRC_TIMER0  = 3;
  localparam int SRC_EXT1    = 4;
  localparam int SRC_TIMER1  = 5;
  localparam int SRC_TWOWIRE = 6;
  localparam int SRC_SERIAL  = 7;
  localparam int SRC_TIMER2  = 8;

  // Vector table, indexed by polling position
  localparam logic [15:0] VECTOR_EXT0    = 16'h0003;
  localparam logic [15:0] VECTOR_TIMER0  = 16'h000b;
  localparam logic [15:0] VECTOR_EXT1    = 16'h0013;
  localparam logic [15:0] VECTOR_TIMER1  = 16'h001b;
  localparam logic [15:0] VECTOR_SERIAL  = 16'h0023;
  localparam logic [15:0] VECTOR_TIMER2  = 16'h002b;
  localparam logic [15:0] VECTOR_CONV    = 16'h0033;
  localparam logic [15:0] VECTOR_TWOWIRE = 16'h003b;
  localparam logic [15:0] VECTOR_SUPPLY  = 16'h0043;
  localparam logic [15:0] VECTOR_TABLE [NUM_SOURCES] = '{
    VECTOR_SUPPLY, VECTOR_EXT0, VECTOR_CONV, VECTOR_TIMER0, VECTOR_EXT1,
    VECTOR_TIMER1, VECTOR_TWOWIRE, VECTOR_SERIAL, VECTOR_TIMER2};

  ////////////////////////////////////////////////////////////////////////
  // Peripheral flags, all on the core clock
  typedef struct packed {
    logic supply_monitor_flag;
    logic ext0_flag;
    logic converter_done_flag;
    logic timer0_overflow_flag;
    logic ext1_flag;
    logic timer1_overflow_flag;
    logic twowire_flag;
    logic spi_done_flag;
    logic receive_done_flag;
    logic send_done_flag;
    logic timer2_overflow_flag;
    logic timer2_external_flag;
  } tlv_flags_s;

  // Service nesting state
  typedef enum logic [1:0] {
    SVC_NONE,
    SVC_LOW,
    SVC_HIGH,
    SVC_HIGH_OVER_LOW
  } tlv_svc_e;

endpackage

// ### src/tlv_irq_ctrl.sv
// Two-level vectored interrupt controller: enable, priority and vector logic.
// Assumes the core acknowledges a shown request with one IRQ_ACK pulse and
// reports each return from a service routine with one IRQ_RETI pulse.
`timescale 1ns/1ps
module tlv_irq_ctrl
(
  input  wire logic              REF_CLK,
  input  wire logic              NRST,
  input  wire logic              CE,
  input  wire logic [7:0]        SFR_ADDR,
  input  wire logic              SFR_WR,
  input  wire logic [7:0]        SFR_WDATA,
  input  wire logic              SFR_RD,
  output logic      [7:0]        SFR_RDATA,
  input  wire tlv_pkg::tlv_flags_s FLAGS,
  output logic                   IRQ_REQ,
  output logic      [15:0]       IRQ_VECTOR,
  output logic                   IRQ_HIGH,
  input  wire logic              IRQ_ACK,
  input  wire logic              IRQ_RETI
);
  import tlv_pkg::*;

  logic [7:0]             irq_enable_primary;
  logic [7:0]             irq_enable_secondary;
  logic [7:0]             irq_priority_select;
  tlv_svc_e               svc;
  tlv_svc_e               next_svc;
  logic [NUM_SOURCES-1:0] src_flag;
  logic [NUM_SOURCES-1:0] src_on;
  logic [NUM_SOURCES-1:0] src_high;
  logic [NUM_SOURCES-1:0] req_all;
  logic [NUM_SOURCES-1:0] req_hi;
  logic [NUM_SOURCES-1:0] req_lo;
  logic                   hi_allowed;
  logic                   lo_allowed;
  logic                   elig_hi_any;
  logic                   elig_lo_any;
  logic [3:0]             hi_idx;
  logic [3:0]             lo_idx;
  logic [3:0]             win_idx;
  logic                   next_req;
  logic [7:0]             next_rdata;
  logic                   wr_primary;
  logic                   wr_secondary;
  logic                   wr_priority;

  // Lowest set index wins; a plain scan keeps the polling order explicit
  function automatic logic [3:0] first_set(input logic [NUM_SOURCES-1:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Register decode
  assign wr_primary   = CE && SFR_WR && (SFR_ADDR == ADDR_ENABLE_PRIMARY);
  assign wr_secondary = CE && SFR_WR && (SFR_ADDR == ADDR_ENABLE_SECONDARY);
  assign wr_priority  = CE && SFR_WR && (SFR_ADDR == ADDR_PRIORITY_SELECT);

  // Reserved secondary bits and unmapped addresses read as zero
  assign next_rdata =
    (SFR_ADDR == ADDR_ENABLE_PRIMARY)   ? irq_enable_primary :
    (SFR_ADDR == ADDR_ENABLE_SECONDARY) ? irq_enable_secondary :
    (SFR_ADDR == ADDR_PRIORITY_SELECT)  ? irq_priority_select : REG_RESET;

  // Configuration registers
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      irq_enable_primary   <= REG_RESET;
      irq_enable_secondary <= REG_RESET;
      irq_priority_select  <= REG_RESET;
      SFR_RDATA            <= REG_RESET;
    end else begin
      if (wr_primary) begin
        irq_enable_primary <= SFR_WDATA;
      end
      if (wr_secondary) begin
        irq_enable_secondary <= SFR_WDATA & SECONDARY_USED_MASK;
      end
      if (wr_priority) begin
        irq_priority_select <= SFR_WDATA;
      end
      if (CE && SFR_RD) begin
        SFR_RDATA <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-source flag, enable and level, in polling order
  // Shared sources are ORed before gating
  assign src_flag[SRC_SUPPLY]  = FLAGS.supply_monitor_flag;
  assign src_flag[SRC_EXT0]    = FLAGS.ext0_flag;
  assign src_flag[SRC_CONV]    = FLAGS.converter_done_flag;
  assign src_flag[SRC_TIMER0]  = FLAGS.timer0_overflow_flag;
  assign src_flag[SRC_EXT1]    = FLAGS.ext1_flag;
  assign src_flag[SRC_TIMER1]  = FLAGS.timer1_overflow_flag;
  assign src_flag[SRC_TWOWIRE] = FLAGS.twowire_flag | FLAGS.spi_done_flag;
  assign src_flag[SRC_SERIAL]  = FLAGS.receive_done_flag | FLAGS.send_done_flag;
  assign src_flag[SRC_TIMER2]  = FLAGS.timer2_overflow_flag | FLAGS.timer2_external_flag;

  // Individual enables
  assign src_on[SRC_SUPPLY]  = irq_enable_secondary[SUPPLY_MONITOR_IRQ_ON];
  assign src_on[SRC_EXT0]    = irq_enable_primary[EXT0_IRQ_ON];
  assign src_on[SRC_CONV]    = irq_enable_primary[CONVERTER_IRQ_ON];
  assign src_on[SRC_TIMER0]  = irq_enable_primary[TIMER0_IRQ_ON];
  assign src_on[SRC_EXT1]    = irq_enable_primary[EXT1_IRQ_ON];
  assign src_on[SRC_TIMER1]  = irq_enable_primary[TIMER1_IRQ_ON];
  assign src_on[SRC_TWOWIRE] = irq_enable_secondary[TWOWIRE_SPI_IRQ_ON];
  assign src_on[SRC_SERIAL]  = irq_enable_primary[UART_IRQ_ON];
  assign src_on[SRC_TIMER2]  = irq_enable_primary[TIMER2_IRQ_ON];

  // Level select; supply monitor has no bit and stays low
  assign src_high[SRC_SUPPLY]  = 1'b0;
  assign src_high[SRC_EXT0]    = irq_priority_select[EXT0_LEVEL];
  assign src_high[SRC_CONV]    = irq_priority_select[CONVERTER_LEVEL];
  assign src_high[SRC_TIMER0]  = irq_priority_select[TIMER0_LEVEL];
  assign src_high[SRC_EXT1]    = irq_priority_select[EXT1_LEVEL];
  assign src_high[SRC_TIMER1]  = irq_priority_select[TIMER1_LEVEL];
  assign src_high[SRC_TWOWIRE] = irq_priority_select[TWOWIRE_SPI_LEVEL];
  assign src_high[SRC_SERIAL]  = irq_priority_select[UART_LEVEL];
  assign src_high[SRC_TIMER2]  = irq_priority_select[TIMER2_LEVEL];

  ////////////////////////////////////////////////////////////////////////
  // Arbitration across nine sources and two levels
  assign req_all = src_flag & src_on & {NUM_SOURCES{irq_enable_primary[GLOBAL_IRQ_GATE]}};
  assign req_hi  = req_all & src_high;
  assign req_lo  = req_all & ~src_high;

  // A high routine blocks everything; a low routine blocks only low
  assign hi_allowed  = (svc == SVC_NONE) || (svc == SVC_LOW);
  assign lo_allowed  = (svc == SVC_NONE);
  assign elig_hi_any = hi_allowed && (|req_hi);
  assign elig_lo_any = lo_allowed && (|req_lo);
  assign hi_idx      = first_set(req_hi);
  assign lo_idx      = first_set(req_lo);
  assign win_idx     = elig_hi_any ? hi_idx : lo_idx;

  // Request drops the cycle after an ack so the core never takes it twice
  assign next_req = (elig_hi_any || elig_lo_any) && !IRQ_ACK;

  // Nesting update; an ack in the same cycle as a return still counts
  always_comb begin
    next_svc = svc;
    if (IRQ_RETI) begin
      case (svc)
        SVC_HIGH_OVER_LOW: next_svc = SVC_LOW;
        SVC_HIGH:          next_svc = SVC_NONE;
        SVC_LOW:           next_svc = SVC_NONE;
        default:           next_svc = SVC_NONE;
      endcase
    end
    if (IRQ_ACK && IRQ_REQ) begin
      if (IRQ_HIGH) begin
        next_svc = (next_svc == SVC_LOW) ? SVC_HIGH_OVER_LOW : SVC_HIGH;
      end else begin
        next_svc = SVC_LOW;
      end
    end
  end

  // Core-facing outputs and nesting state
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      svc        <= SVC_NONE;
      IRQ_REQ    <= 1'b0;
      IRQ_HIGH   <= 1'b0;
      IRQ_VECTOR <= VECTOR_EXT0;
    end else if (CE) begin
      svc        <= next_svc;
      IRQ_REQ    <= next_req;
      IRQ_HIGH   <= elig_hi_any;
      IRQ_VECTOR <= VECTOR_TABLE[win_idx];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  a_gate_blocks_all: assert property ((CE && !irq_enable_primary[GLOBAL_IRQ_GATE])
    |=> !IRQ_REQ) else $error("request raised with global gate off");
  a_ext0_disabled: assert property ((CE && !irq_enable_primary[EXT0_IRQ_ON])
    |=> !(IRQ_REQ && IRQ_VECTOR == VECTOR_EXT0))
    else $error("disabled external 0 was vectored");
  a_supply_disabled: assert property ((CE && !irq_enable_secondary[SUPPLY_MONITOR_IRQ_ON])
    |=> !(IRQ_REQ && IRQ_VECTOR == VECTOR_SUPPLY))
    else $error("disabled supply monitor was vectored");
  a_reset_clears: assert property (@(posedge REF_CLK) disable iff (1'b0)
    !NRST |=> (irq_enable_primary == REG_RESET && irq_enable_secondary == REG_RESET
               && irq_priority_select == REG_RESET && !IRQ_REQ))
    else $error("registers not cleared by reset");
  a_high_first: assert property ((CE && !IRQ_ACK && !IRQ_RETI && svc == SVC_NONE
    && irq_enable_primary[GLOBAL_IRQ_GATE] && irq_enable_primary[EXT0_IRQ_ON]
    && irq_priority_select[EXT0_LEVEL] && FLAGS.ext0_flag)
    |=> (IRQ_REQ && IRQ_HIGH && IRQ_VECTOR == VECTOR_EXT0))
    else $error("high level request not served first");
  a_high_preempts: assert property ((CE && !IRQ_ACK && svc == SVC_LOW && |req_hi)
    |=> (IRQ_REQ && IRQ_HIGH)) else $error("high request did not preempt");
  a_same_level_held: assert property ((CE && svc == SVC_LOW && !(|req_hi))
    |=> !IRQ_REQ) else $error("low routine preempted by low request");
  a_high_no_nest: assert property ((CE && (svc == SVC_HIGH || svc == SVC_HIGH_OVER_LOW))
    |=> !IRQ_REQ) else $error("high routine preempted");
  a_poll_supply: assert property ((CE && !IRQ_ACK && svc == SVC_NONE && !(|req_hi)
    && req_lo[SRC_SUPPLY]) |=> (IRQ_REQ && !IRQ_HIGH && IRQ_VECTOR == VECTOR_SUPPLY))
    else $error("supply monitor not first in polling");
  a_vector_form: assert property (IRQ_REQ |-> (IRQ_VECTOR[2:0] == 3'h3
    && IRQ_VECTOR <= VECTOR_SUPPLY)) else $error("malformed vector");
  a_ack_enters: assert property ((CE && IRQ_ACK && IRQ_REQ && IRQ_HIGH)
    |=> ((svc == SVC_HIGH || svc == SVC_HIGH_OVER_LOW) && !IRQ_REQ) ##1 !IRQ_REQ)
    else $error("ack of high request not recorded");

  c_nested: cover property (svc == SVC_LOW ##[1:20] svc == SVC_HIGH_OVER_LOW);
  c_mixed: cover property (CE && |req_hi && |req_lo && svc == SVC_NONE);
  c_return: cover property (svc == SVC_HIGH_OVER_LOW ##[1:20] svc == SVC_LOW);
  c_tie: cover property (CE && $countones(req_lo) > 1 && svc == SVC_NONE);

endmodule

// ### verif/tlv_core_model.sv
// Behavioural core: accepts shown requests and returns from routines.
// Assumes IRQ_REQ is stable from just after each REF_CLK rising edge.
`timescale 1ns/1ps
module tlv_core_model (
  input  wire logic        REF_CLK,
  input  wire logic        IRQ_REQ,
  input  wire logic [15:0] IRQ_VECTOR,
  input  wire logic        ACK_EN,
  input  wire logic        RET_CMD,
  output logic             IRQ_ACK,
  output logic             IRQ_RETI,
  output logic      [15:0] PC
);
  logic [15:0] stack [$];
  logic        take_ack;
  logic        take_ret;

  initial begin
    IRQ_ACK  = 1'b0;
    IRQ_RETI = 1'b0;
    PC       = 16'h0000;
  end

  //////////////////////////////////////////////////////////////////////////
  // Commands sampled on the edge, answers launched just after it
  // A return wins over an accept so the two never share one edge
  always @(posedge REF_CLK) begin
    take_ack = ACK_EN;
    take_ret = RET_CMD;
    #1;
    IRQ_RETI = take_ret;
    IRQ_ACK  = !take_ret && take_ack && IRQ_REQ;
    if (take_ret && stack.size() > 0) begin
      PC = stack.pop_back();
    end else if (IRQ_ACK) begin
      stack.push_back(PC);
      PC = IRQ_VECTOR;
    end
  end
endmodule

// ### verif/tlv_irq_ctrl_test.sv
// Self-checking bench for the interrupt controller.
// Assumes the core model above on the core link; CE dropped once to test the freeze.
`timescale 1ns/1ps
module tlv_irq_ctrl_test;
  import tlv_pkg::*;
  localparam logic [7:0] A_PRI = ADDR_ENABLE_PRIMARY;
  localparam logic [7:0] A_SEC = ADDR_ENABLE_SECONDARY;
  localparam logic [7:0] A_LVL = ADDR_PRIORITY_SELECT;
  logic        ref_clk   = 1'b0;
  logic        nrst      = 1'b0;
  logic        ce        = 1'b1;
  logic [7:0]  sfr_addr  = 8'h00;
  logic        sfr_wr    = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic        sfr_rd    = 1'b0;
  logic [7:0]  sfr_rdata;
  logic [11:0] flag_bits = 12'h000;
  logic        irq_req;
  logic [15:0] irq_vector;
  logic        irq_high;
  logic        irq_ack;
  logic        irq_reti;
  logic        ack_en    = 1'b0;
  logic        ret_cmd   = 1'b0;
  logic [15:0] core_pc;
  int          error_cnt = 0;
  int          checked   = 0;
  // Flag bits per polling position, supply monitor in the top bit
  logic [11:0] src_mask [9] = '{12'h800, 12'h400, 12'h200, 12'h100, 12'h080,
                                12'h040, 12'h030, 12'h00c, 12'h003};
  // Polling position behind each level bit and primary enable bits 0 to 6
  int          bit_src [8] = '{1, 3, 4, 5, 7, 8, 2, 6};

  always #25 ref_clk = ~ref_clk;

  tlv_irq_ctrl i_tlv_irq_ctrl (
    .REF_CLK    (ref_clk),
    .NRST       (nrst),
    .CE         (ce),
    .SFR_ADDR   (sfr_addr),
    .SFR_WR     (sfr_wr),
    .SFR_WDATA  (sfr_wdata),
    .SFR_RD     (sfr_rd),
    .SFR_RDATA  (sfr_rdata),
    .FLAGS      (tlv_flags_s'(flag_bits)),
    .IRQ_REQ    (irq_req),
    .IRQ_VECTOR (irq_vector),
    .IRQ_HIGH   (irq_high),
    .IRQ_ACK    (irq_ack),
    .IRQ_RETI   (irq_reti)
  );

  tlv_core_model i_tlv_core_model (
    .REF_CLK    (ref_clk),
    .IRQ_REQ    (irq_req),
    .IRQ_VECTOR (irq_vector),
    .ACK_EN     (ack_en),
    .RET_CMD    (ret_cmd),
    .IRQ_ACK    (irq_ack),
    .IRQ_RETI   (irq_reti),
    .PC         (core_pc)
  );

  //////////////////////////////////////////////////////////////////////////
  // Shared tasks; every step ends just after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic complete_run();
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Spare cycle after the strobe so back-to-back calls never re-drive it
  task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
    sfr_addr  = addr;
    sfr_wdata = data;
    sfr_wr    = 1'b1;
    tick(1);
    sfr_wr    = 1'b0;
    tick(1);
  endtask

  task automatic sfr_read(input logic [7:0] addr, input logic [7:0] exp);
    sfr_addr = addr;
    sfr_rd   = 1'b1;
    tick(1);
    sfr_rd   = 1'b0;
    tick(1);
    chk("read data", {8'h00, exp}, {8'h00, sfr_rdata});
  endtask

  task automatic expect_req(input int src, input logic high);
    tick(2);
    chk("request", 16'h0001, {15'h0000, irq_req});
    chk("vector", VECTOR_TABLE[src], irq_vector);
    chk("level", {15'h0000, high}, {15'h0000, irq_high});
  endtask

  // Bounded wait for the core to land on a vector
  task automatic wait_pc(input logic [15:0] exp);
    int n;
    n = 0;
    while (core_pc !== exp && n < 20) begin
      tick(1);
      n++;
    end
    chk("core pc", exp, core_pc);
    if (core_pc !== exp) complete_run();
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    tick(6);
    nrst = 1'b1;
    sfr_read(A_PRI, 8'h00);
    sfr_read(A_SEC, 8'h00);
    sfr_read(A_LVL, 8'h00);
    sfr_write(8'haa, 8'h55);
    sfr_read(8'haa, 8'h00);
    sfr_write(A_SEC, 8'hff);
    sfr_read(A_SEC, 8'h03);
    sfr_write(A_LVL, 8'h5a);
    sfr_read(A_LVL, 8'h5a);
    sfr_write(A_LVL, 8'h00);
    // Everything pending but the gate closed, then gate open alone
    flag_bits = 12'hfff;
    sfr_write(A_PRI, 8'h7f);
    sfr_read(A_PRI, 8'h7f);
    chk("gated request", 16'h0000, {15'h0000, irq_req});
    sfr_write(A_SEC, 8'h00);
    sfr_write(A_PRI, 8'h80);
    tick(2);
    chk("no enables", 16'h0000, {15'h0000, irq_req});
    // Each enable bit on its own selects its source
    for (int i = 0; i < 8; i++) begin
      sfr_write(A_PRI, (i < 7) ? (8'h80 | (8'h01 << i)) : 8'h80);
      sfr_write(A_SEC, (i < 7) ? 8'h00 : 8'h01);
      expect_req(bit_src[i], 1'b0);
    end
    sfr_write(A_SEC, 8'h02);
    expect_req(SRC_SUPPLY, 1'b0);
    // One flag per source, shared sources through their second flag
    sfr_write(A_PRI, 8'hff);
    sfr_write(A_SEC, 8'h03);
    for (int i = 0; i < NUM_SOURCES; i++) begin
      flag_bits = src_mask[i] & (~src_mask[i] + 12'h001);
      expect_req(i, 1'b0);
      // Shared sources once more through their first flag alone
      flag_bits = src_mask[i] & (src_mask[i] - 12'h001);
      if (flag_bits != 12'h000) expect_req(i, 1'b0);
    end
    // All pending at low level, drained in polling order
    flag_bits = 12'hfff;
    for (int i = 0; i < NUM_SOURCES; i++) begin
      expect_req(i, 1'b0);
      flag_bits = flag_bits & ~src_mask[i];
    end
    // Clock enable low freezes the shown request and the registers
    flag_bits = 12'hfff;
    tick(2);
    ce        = 1'b0;
    flag_bits = 12'h000;
    sfr_write(A_PRI, 8'h00);
    chk("frozen request", 16'h0001, {15'h0000, irq_req});
    chk("frozen vector", VECTOR_SUPPLY, irq_vector);
    ce        = 1'b1;
    sfr_read(A_PRI, 8'hff);
    // A single high source beats all low ones, supply monitor included
    flag_bits = 12'hfff;
    for (int i = 0; i < 8; i++) begin
      sfr_write(A_LVL, 8'h01 << i);
      expect_req(bit_src[i], 1'b1);
    end
    // Nesting: low routine, high preempts, same level never does
    sfr_write(A_LVL, 8'h02);
    flag_bits = 12'h480;
    ack_en    = 1'b1;
    wait_pc(VECTOR_EXT0);
    tick(4);
    chk("low over low", VECTOR_EXT0, core_pc);
    flag_bits = 12'h580;
    wait_pc(VECTOR_TIMER0);
    sfr_write(A_LVL, 8'h06);
    tick(4);
    chk("high over high", VECTOR_TIMER0, core_pc);
    flag_bits = 12'h480;
    ret_cmd   = 1'b1;
    tick(1);
    ret_cmd   = 1'b0;
    wait_pc(VECTOR_EXT1);
    flag_bits = 12'h000;
    ret_cmd   = 1'b1;
    tick(2);
    ret_cmd   = 1'b0;
    wait_pc(16'h0000);
    complete_run();
  end
endmodule
